// *** rtl/timer_trio.sv ***
// Three timer/counters with capture and reload behind an APB slave
//
// What this block does
// - Timer tick is clock/12 or clock/4
// - Count pins sampled at C4, high-then-low counts
// - Counts update at C3, edge counts next cycle
// - Function bits 2 and 6 select tick or edge
// - Two-bit mode field for timer zero and timer one
// - Turbo bits reset to 0, 1 selects /4
// - Mode 0 is 13 bits, upper low bits ignored
// - Mode 0 carry at low bit 5, flag on wrap
// - Count needs run and gate bit clear or gate pin high
// - Mode 1 is 16 bits, flag on wrap
// - Mode 2 low byte reloads from high byte
// - Timer one mode 3 freezes its count
// - Timer zero mode 3 splits into two bytes
// - Split: timer one runs by its own mode
// - Timer2 ticks from pin or divider while running
// - Timer2 capture mode counts 16 bits, flags wrap
// - Trigger edge captures count, sets external flag
// - Capture clear bit zeroes count after capture
// - Up reload loads capture bytes on wrap
// - Trigger edge also reloads, sets external flag
// - Zero/one overflow flags set at C3
// - Vectoring clears zero/one flags, timer2 software
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "timer_trio_params.svh"

module timer_trio (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire timer_trio_pkg::addr_t PADDR,
  input wire timer_trio_pkg::word_t PWDATA,
  output timer_trio_pkg::word_t PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // External pins
  input wire logic COUNT_INPUT_ZERO,
  input wire logic COUNT_INPUT_ONE,
  input wire logic GATE_PIN_ZERO,
  input wire logic GATE_PIN_ONE,
  input wire logic TIMER2_COUNT_PIN,
  input wire logic TIMER2_TRIGGER_PIN,
  // Vector acknowledge from the core
  input wire logic VECTOR_ACK_ZERO,
  input wire logic VECTOR_ACK_ONE,
  // Interrupt flags
  output logic OVERFLOW_FLAG_ZERO,
  output logic OVERFLOW_FLAG_ONE,
  output logic TIMER2_OVERFLOW_FLAG,
  output logic TIMER2_EXTERNAL_FLAG
);
  import timer_trio_pkg::*;

  timer_state_t s;
  timer_state_t next_s;
  cycle_if cyc ();

  cycle_gen u_cycle_gen (
    .clock(CLOCK),
    .reset_n(RESET_N),
    .cyc(cyc.source)
  );

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  // One count step of timer zero or one: {overflow, high, low}
  function automatic logic [16:0] timer_step(input logic [1:0] mode, input byte_t hi,
                                             input byte_t lo);
    logic [16:0] sum;
    logic [5:0] low5;
    logic [8:0] high9;
    logic [8:0] low9;
    sum = '0;
    low5 = '0;
    high9 = '0;
    low9 = '0;
    case (mode)
      `MODE_13BIT: begin
        low5 = {1'b0, lo[4:0]} + 6'h01;
        high9 = {1'b0, hi} + {8'h00, (lo[4:0] == `LOW5_FULL)};
        timer_step = {high9[8] & (lo[4:0] == `LOW5_FULL), high9[7:0], lo[7:5], low5[4:0]};
      end
      `MODE_16BIT: begin
        sum = {1'b0, hi, lo} + `INC_ONE;
        timer_step = sum;
      end
      `MODE_RELOAD: begin
        if (lo == `BYTE_FULL) begin
          timer_step = {1'b1, hi, hi};
        end else begin
          low9 = {1'b0, lo} + `INC_BYTE;
          timer_step = {1'b0, hi, low9[7:0]};
        end
      end
      default: timer_step = {1'b0, hi, lo};
    endcase
  endfunction

  // Known register offsets
  function automatic logic addr_hit(input addr_t addr);
    case (addr)
      `OFF_TIMER_MODE, `OFF_TIMER_CONTROL, `OFF_CLOCK_CONTROL, `OFF_TIMER2_CONTROL,
      `OFF_TIMER2_MODE, `OFF_ZERO_LOW, `OFF_ZERO_HIGH, `OFF_ONE_LOW, `OFF_ONE_HIGH,
      `OFF_TIMER2_LOW, `OFF_TIMER2_HIGH, `OFF_CAPTURE_LOW, `OFF_CAPTURE_HIGH: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  logic base_zero;
  logic base_one;
  logic base_two;
  logic in_zero;
  logic in_one;
  logic in_two;
  logic run_zero;
  logic run_one;
  logic gate_ok_zero;
  logic gate_ok_one;
  logic split;
  logic set_ovf_zero;
  logic set_ovf_one;
  logic set_ovf_two;
  logic set_ext_two;
  logic capture_mode;
  logic reload_mode;
  logic trigger;
  logic [16:0] step;
  logic [8:0] byte_sum;
  logic [16:0] count2_sum;
  logic bus_write;

  always_comb begin
    next_s = s;
    step = '0;
    byte_sum = '0;
    set_ovf_zero = 1'b0;
    set_ovf_one = 1'b0;
    set_ovf_two = 1'b0;
    set_ext_two = 1'b0;

    // Pin synchronisers
    next_s.sync_first = {TIMER2_TRIGGER_PIN, TIMER2_COUNT_PIN, COUNT_INPUT_ONE,
                         COUNT_INPUT_ZERO, GATE_PIN_ONE, GATE_PIN_ZERO};
    next_s.sync_second = s.sync_first;

    // Edge detection at C4, consumed at the next C3
    if (cyc.sample_strobe) begin
      next_s.sample = s.sync_second[5:2];
      next_s.edge_pending = s.sample & ~s.sync_second[5:2];
    end else if (cyc.tick_quarter) begin
      next_s.edge_pending = '0;
    end

    // Time bases
    base_zero = s.clock_control_register[`TURBO_ZERO_BIT] ? cyc.tick_quarter
                                                          : cyc.tick_twelfth;
    base_one = s.clock_control_register[`TURBO_ONE_BIT] ? cyc.tick_quarter
                                                        : cyc.tick_twelfth;
    base_two = s.clock_control_register[`TURBO_TWO_BIT] ? cyc.tick_quarter
                                                        : cyc.tick_twelfth;

    // Counted inputs
    in_zero = s.timer_mode_register[`FUNC_ZERO_BIT] ?
              (cyc.tick_quarter & s.edge_pending[0]) : base_zero;
    in_one = s.timer_mode_register[`FUNC_ONE_BIT] ?
             (cyc.tick_quarter & s.edge_pending[1]) : base_one;
    in_two = s.timer2_control_register[`FUNC_TWO_BIT] ?
             (cyc.tick_quarter & s.edge_pending[2]) : base_two;

    // Gating
    gate_ok_zero = !s.timer_mode_register[`GATE_ZERO_BIT] || s.sync_second[0];
    gate_ok_one = !s.timer_mode_register[`GATE_ONE_BIT] || s.sync_second[1];
    split = (s.timer_mode_register[`MODE_FIELD_ZERO] == `MODE_SPLIT);
    run_zero = s.timer_control_register[`RUN_ZERO_BIT] && gate_ok_zero;
    run_one = split ? gate_ok_one : s.timer_control_register[`RUN_ONE_BIT] && gate_ok_one;

    // Timer zero
    if (!split) begin
      if (run_zero && in_zero) begin
        step = timer_step(s.timer_mode_register[`MODE_FIELD_ZERO], s.timer_zero_high_byte,
                          s.timer_zero_low_byte);
        next_s.timer_zero_high_byte = step[15:8];
        next_s.timer_zero_low_byte = step[7:0];
        set_ovf_zero = step[16];
      end
    end else begin
      if (run_zero && in_zero) begin
        byte_sum = {1'b0, s.timer_zero_low_byte} + `INC_BYTE;
        next_s.timer_zero_low_byte = byte_sum[7:0];
        set_ovf_zero = byte_sum[8];
      end
      if (s.timer_control_register[`RUN_ONE_BIT] && base_zero) begin
        byte_sum = {1'b0, s.timer_zero_high_byte} + `INC_BYTE;
        next_s.timer_zero_high_byte = byte_sum[7:0];
        set_ovf_one = byte_sum[8];
      end
    end

    // Timer one
    if (run_one && in_one) begin
      step = timer_step(s.timer_mode_register[`MODE_FIELD_ONE], s.timer_one_high_byte,
                        s.timer_one_low_byte);
      next_s.timer_one_high_byte = step[15:8];
      next_s.timer_one_low_byte = step[7:0];
      if (!split) begin
        set_ovf_one = step[16];
      end
    end

    // Timer two
    capture_mode = s.timer2_control_register[`CAP_RELOAD_BIT] &&
                   !s.timer2_control_register[`RX_CLK_SRC_BIT] &&
                   !s.timer2_control_register[`TX_CLK_SRC_BIT];
    reload_mode = !s.timer2_control_register[`CAP_RELOAD_BIT] &&
                  !s.timer2_control_register[`RX_CLK_SRC_BIT] &&
                  !s.timer2_control_register[`TX_CLK_SRC_BIT] &&
                  !s.timer2_mode_register[`UP_DOWN_BIT] &&
                  !s.timer2_mode_register[`CLK_OUT_BIT];
    trigger = cyc.tick_quarter && s.edge_pending[3] &&
              s.timer2_control_register[`EXT_ENABLE_BIT];
    count2_sum = {1'b0, s.timer2_high_byte, s.timer2_low_byte} + `INC_ONE;

    if (capture_mode) begin
      if (s.timer2_control_register[`RUN_TWO_BIT] && in_two) begin
        next_s.timer2_high_byte = count2_sum[15:8];
        next_s.timer2_low_byte = count2_sum[7:0];
        set_ovf_two = count2_sum[16];
      end
      if (trigger) begin
        next_s.capture_high_byte = s.timer2_high_byte;
        next_s.capture_low_byte = s.timer2_low_byte;
        set_ext_two = 1'b1;
        if (s.timer2_mode_register[`CAP_CLEAR_BIT]) begin
          next_s.timer2_high_byte = `RESET_BYTE;
          next_s.timer2_low_byte = `RESET_BYTE;
        end
      end
    end else if (reload_mode) begin
      if (s.timer2_control_register[`RUN_TWO_BIT] && in_two) begin
        if (count2_sum[16]) begin
          next_s.timer2_high_byte = s.capture_high_byte;
          next_s.timer2_low_byte = s.capture_low_byte;
          set_ovf_two = 1'b1;
        end else begin
          next_s.timer2_high_byte = count2_sum[15:8];
          next_s.timer2_low_byte = count2_sum[7:0];
        end
      end
      if (trigger) begin
        next_s.timer2_high_byte = s.capture_high_byte;
        next_s.timer2_low_byte = s.capture_low_byte;
        set_ext_two = 1'b1;
      end
    end

    // Register read data, loaded in the setup cycle
    if (PSEL && !PENABLE) begin
      case (PADDR)
        `OFF_TIMER_MODE: next_s.read_data = s.timer_mode_register;
        `OFF_TIMER_CONTROL: next_s.read_data = s.timer_control_register;
        `OFF_CLOCK_CONTROL: next_s.read_data = s.clock_control_register;
        `OFF_TIMER2_CONTROL: next_s.read_data = s.timer2_control_register;
        `OFF_TIMER2_MODE: next_s.read_data = s.timer2_mode_register;
        `OFF_ZERO_LOW: next_s.read_data = s.timer_zero_low_byte;
        `OFF_ZERO_HIGH: next_s.read_data = s.timer_zero_high_byte;
        `OFF_ONE_LOW: next_s.read_data = s.timer_one_low_byte;
        `OFF_ONE_HIGH: next_s.read_data = s.timer_one_high_byte;
        `OFF_TIMER2_LOW: next_s.read_data = s.timer2_low_byte;
        `OFF_TIMER2_HIGH: next_s.read_data = s.timer2_high_byte;
        `OFF_CAPTURE_LOW: next_s.read_data = s.capture_low_byte;
        `OFF_CAPTURE_HIGH: next_s.read_data = s.capture_high_byte;
        default: next_s.read_data = `RESET_BYTE;
      endcase
    end

    // Register writes override the count of the same cycle
    bus_write = PSEL && PENABLE && PWRITE;
    if (bus_write) begin
      case (PADDR)
        `OFF_TIMER_MODE: next_s.timer_mode_register = PWDATA[7:0];
        `OFF_TIMER_CONTROL: next_s.timer_control_register = PWDATA[7:0];
        `OFF_CLOCK_CONTROL: next_s.clock_control_register = PWDATA[7:0];
        `OFF_TIMER2_CONTROL: next_s.timer2_control_register = PWDATA[7:0];
        `OFF_TIMER2_MODE: next_s.timer2_mode_register = PWDATA[7:0];
        `OFF_ZERO_LOW: next_s.timer_zero_low_byte = PWDATA[7:0];
        `OFF_ZERO_HIGH: next_s.timer_zero_high_byte = PWDATA[7:0];
        `OFF_ONE_LOW: next_s.timer_one_low_byte = PWDATA[7:0];
        `OFF_ONE_HIGH: next_s.timer_one_high_byte = PWDATA[7:0];
        `OFF_TIMER2_LOW: next_s.timer2_low_byte = PWDATA[7:0];
        `OFF_TIMER2_HIGH: next_s.timer2_high_byte = PWDATA[7:0];
        `OFF_CAPTURE_LOW: next_s.capture_low_byte = PWDATA[7:0];
        `OFF_CAPTURE_HIGH: next_s.capture_high_byte = PWDATA[7:0];
        default: next_s.read_data = s.read_data;
      endcase
    end

    // Flags: hardware set wins over any clear
    next_s.timer_control_register[`OVF_ZERO_BIT] =
      (next_s.timer_control_register[`OVF_ZERO_BIT] & ~VECTOR_ACK_ZERO) | set_ovf_zero;
    next_s.timer_control_register[`OVF_ONE_BIT] =
      (next_s.timer_control_register[`OVF_ONE_BIT] & ~VECTOR_ACK_ONE) | set_ovf_one;
    next_s.timer2_control_register[`OVF_TWO_BIT] =
      next_s.timer2_control_register[`OVF_TWO_BIT] | set_ovf_two;
    next_s.timer2_control_register[`EXT_FLAG_BIT] =
      next_s.timer2_control_register[`EXT_FLAG_BIT] | set_ext_two;
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign PRDATA = {24'h000000, s.read_data};
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_hit(PADDR);
  assign OVERFLOW_FLAG_ZERO = s.timer_control_register[`OVF_ZERO_BIT];
  assign OVERFLOW_FLAG_ONE = s.timer_control_register[`OVF_ONE_BIT];
  assign TIMER2_OVERFLOW_FLAG = s.timer2_control_register[`OVF_TWO_BIT];
  assign TIMER2_EXTERNAL_FLAG = s.timer2_control_register[`EXT_FLAG_BIT];

endmodule

`default_nettype wire

// *** rtl/timer_trio_params.svh ***
// Offsets, field positions, reset values and timing counts of the timer trio
`ifndef TIMER_TRIO_PARAMS_SVH
`define TIMER_TRIO_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFF_TIMER_MODE 8'h00
`define OFF_TIMER_CONTROL 8'h04
`define OFF_CLOCK_CONTROL 8'h08
`define OFF_TIMER2_CONTROL 8'h0C
`define OFF_TIMER2_MODE 8'h10
`define OFF_ZERO_LOW 8'h14
`define OFF_ZERO_HIGH 8'h18
`define OFF_ONE_LOW 8'h1C
`define OFF_ONE_HIGH 8'h20
`define OFF_TIMER2_LOW 8'h24
`define OFF_TIMER2_HIGH 8'h28
`define OFF_CAPTURE_LOW 8'h2C
`define OFF_CAPTURE_HIGH 8'h30

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define MODE_FIELD_ZERO 1:0
`define FUNC_ZERO_BIT 2
`define GATE_ZERO_BIT 3
`define MODE_FIELD_ONE 5:4
`define FUNC_ONE_BIT 6
`define GATE_ONE_BIT 7
`define RUN_ZERO_BIT 4
`define OVF_ZERO_BIT 5
`define RUN_ONE_BIT 6
`define OVF_ONE_BIT 7
`define TURBO_ZERO_BIT 3
`define TURBO_ONE_BIT 4
`define TURBO_TWO_BIT 5
`define CAP_RELOAD_BIT 0
`define FUNC_TWO_BIT 1
`define RUN_TWO_BIT 2
`define EXT_ENABLE_BIT 3
`define TX_CLK_SRC_BIT 4
`define RX_CLK_SRC_BIT 5
`define EXT_FLAG_BIT 6
`define OVF_TWO_BIT 7
`define UP_DOWN_BIT 0
`define CLK_OUT_BIT 1
`define CAP_CLEAR_BIT 3

// ----------------------------------------------------------------------------
// Values and timing
// ----------------------------------------------------------------------------
`define RESET_BYTE 8'h00
`define RESET_WORD 16'h0000
`define STD_DIV_LAST 2'h2
`define MODE_13BIT 2'h0
`define MODE_16BIT 2'h1
`define MODE_RELOAD 2'h2
`define MODE_SPLIT 2'h3
`define LOW5_FULL 5'h1F
`define BYTE_FULL 8'hFF
`define INC_ONE 17'h00001
`define INC_BYTE 9'h001

`endif

// *** rtl/timer_trio_pkg.sv ***
// Types shared by the timer trio modules
package timer_trio_pkg;

  typedef logic [7:0] addr_t;
  typedef logic [7:0] byte_t;
  typedef logic [31:0] word_t;
  typedef logic [15:0] count_t;

  // Machine cycle phases, Gray coded
  typedef enum logic [1:0] {
    PHASE_C1 = 2'h0,
    PHASE_C2 = 2'h1,
    PHASE_C3 = 2'h3,
    PHASE_C4 = 2'h2
  } phase_t;

  typedef struct packed {
    phase_t phase;
    logic [1:0] cycle_count;
  } cycle_state_t;

  typedef struct packed {
    byte_t timer_mode_register;
    byte_t timer_control_register;
    byte_t clock_control_register;
    byte_t timer2_control_register;
    byte_t timer2_mode_register;
    byte_t timer_zero_low_byte;
    byte_t timer_zero_high_byte;
    byte_t timer_one_low_byte;
    byte_t timer_one_high_byte;
    byte_t timer2_low_byte;
    byte_t timer2_high_byte;
    byte_t capture_low_byte;
    byte_t capture_high_byte;
    byte_t read_data;
    logic [5:0] sync_first;
    logic [5:0] sync_second;
    logic [3:0] sample;
    logic [3:0] edge_pending;
  } timer_state_t;

endpackage

// *** rtl/cycle_if.sv ***
// Machine cycle strobes from the phase generator to the timers
`timescale 1ns/1ps
`default_nettype none

interface cycle_if;
  logic tick_quarter;
  logic tick_twelfth;
  logic sample_strobe;
  modport source (output tick_quarter, output tick_twelfth, output sample_strobe);
  modport sink (input tick_quarter, input tick_twelfth, input sample_strobe);
endinterface

`default_nettype wire

// *** rtl/cycle_gen.sv ***
// Four-phase machine cycle generator with time-base strobes
`timescale 1ns/1ps
`default_nettype none
`include "timer_trio_params.svh"

module cycle_gen (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Strobes
  cycle_if.source cyc
);
  import timer_trio_pkg::*;

  cycle_state_t s;
  cycle_state_t next_s;

  // ----------------------------------------------------------------------------
  // Phase sequence
  // ----------------------------------------------------------------------------
  always_comb begin
    next_s = s;
    case (s.phase)
      PHASE_C1: next_s.phase = PHASE_C2;
      PHASE_C2: next_s.phase = PHASE_C3;
      PHASE_C3: next_s.phase = PHASE_C4;
      PHASE_C4: begin
        next_s.phase = PHASE_C1;
        next_s.cycle_count = (s.cycle_count == `STD_DIV_LAST) ? 2'h0 : s.cycle_count + 2'h1;
      end
      default: next_s.phase = PHASE_C1;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Count updates fall in C3, pin sampling in C4
  assign cyc.tick_quarter = (s.phase == PHASE_C3);
  assign cyc.tick_twelfth = (s.phase == PHASE_C3) && (s.cycle_count == `STD_DIV_LAST);
  assign cyc.sample_strobe = (s.phase == PHASE_C4);

endmodule

`default_nettype wire

// *** verification/timer_trio_props.sv ***
// Port assertions for the timer trio
`timescale 1ns/1ps
`default_nettype none
module timer_trio_props (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // Bus
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire timer_trio_pkg::addr_t PADDR,
  input wire timer_trio_pkg::word_t PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Flags and acknowledges
  input wire logic VECTOR_ACK_ZERO,
  input wire logic VECTOR_ACK_ONE,
  input wire logic OVERFLOW_FLAG_ZERO,
  input wire logic OVERFLOW_FLAG_ONE,
  input wire logic TIMER2_OVERFLOW_FLAG,
  input wire logic TIMER2_EXTERNAL_FLAG
);
  import timer_trio_pkg::*;
  logic wr_ctl;
  logic wr_t2;
  assign wr_ctl = PSEL && PENABLE && PWRITE && PADDR == 8'h04;
  assign wr_t2 = PSEL && PENABLE && PWRITE && PADDR == 8'h0C;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  property p_ready;
    PREADY;
  endproperty
  a_ready: assert property (p_ready) else $error("ready low");
  property p_err_phase;
    PSLVERR |-> PSEL && PENABLE;
  endproperty
  a_err_phase: assert property (p_err_phase) else $error("error outside access");
  property p_unmapped;
    PSEL && PENABLE && PADDR == 8'h40 |-> PSLVERR && PRDATA == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  property p_upper;
    PRDATA[31:8] == 24'h000000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_ovf0_hold;
    $fell(OVERFLOW_FLAG_ZERO) |-> $past(VECTOR_ACK_ZERO) || $past(wr_ctl);
  endproperty
  a_ovf0_hold: assert property (p_ovf0_hold) else $error("flag zero lost");
  property p_ovf1_hold;
    $fell(OVERFLOW_FLAG_ONE) |-> $past(VECTOR_ACK_ONE) || $past(wr_ctl);
  endproperty
  a_ovf1_hold: assert property (p_ovf1_hold) else $error("flag one lost");
  property p_t2ovf_hold;
    $fell(TIMER2_OVERFLOW_FLAG) |-> $past(wr_t2);
  endproperty
  a_t2ovf_hold: assert property (p_t2ovf_hold) else $error("timer2 flag lost");
  property p_t2ext_hold;
    $fell(TIMER2_EXTERNAL_FLAG) |-> $past(wr_t2);
  endproperty
  a_t2ext_hold: assert property (p_t2ext_hold) else $error("external flag lost");
  property p_ovf0_phase;
    $rose(OVERFLOW_FLAG_ZERO) && !$past(wr_ctl) |=> !$rose(OVERFLOW_FLAG_ZERO) [*3];
  endproperty
  a_ovf0_phase: assert property (p_ovf0_phase) else $error("flag set off phase");
endmodule
bind timer_trio timer_trio_props chk (.CLOCK(CLOCK), .RESET_N(RESET_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .VECTOR_ACK_ZERO(VECTOR_ACK_ZERO), .VECTOR_ACK_ONE(VECTOR_ACK_ONE),
  .OVERFLOW_FLAG_ZERO(OVERFLOW_FLAG_ZERO), .OVERFLOW_FLAG_ONE(OVERFLOW_FLAG_ONE),
  .TIMER2_OVERFLOW_FLAG(TIMER2_OVERFLOW_FLAG), .TIMER2_EXTERNAL_FLAG(TIMER2_EXTERNAL_FLAG));
`default_nettype wire

// *** verification/pin_model.sv ***
// Far side pins: count, gate and trigger inputs
`timescale 1ns/1ps
`default_nettype none
module pin_model (
  // Clock
  input wire logic clock,
  // Pins: count0, count1, gate0, gate1, timer2 count, trigger
  output var logic [5:0] pins
);
  initial pins = 6'h3F;
  // Long high and low phases give at least one high and one low sample
  task automatic fall(input int i);
    @(posedge clock);
    pins[i] <= 1'b0;
    repeat (12) @(posedge clock);
    pins[i] <= 1'b1;
    repeat (12) @(posedge clock);
  endtask
  task automatic set_pin(input int i, input logic v);
    @(posedge clock);
    pins[i] <= v;
    repeat (4) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for the timer trio
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import timer_trio_pkg::*;
  logic clock;
  logic reset_n;
  logic psel;
  logic penable;
  logic pwrite;
  addr_t paddr;
  word_t pwdata;
  word_t prdata;
  logic pready;
  logic pslverr;
  logic ack0;
  logic ack1;
  logic ovf0, ovf1, ovf2, ext2;
  logic [5:0] pins;
  int err_count = 0;
  int check_count = 0;
  int cycles = 0;
  always #4 clock = ~clock;
  pin_model pm (.clock(clock), .pins(pins));
  timer_trio uut (.CLOCK(clock), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .COUNT_INPUT_ZERO(pins[0]), .COUNT_INPUT_ONE(pins[1]),
    .GATE_PIN_ZERO(pins[2]), .GATE_PIN_ONE(pins[3]), .TIMER2_COUNT_PIN(pins[4]),
    .TIMER2_TRIGGER_PIN(pins[5]), .VECTOR_ACK_ZERO(ack0), .VECTOR_ACK_ONE(ack1),
    .OVERFLOW_FLAG_ZERO(ovf0), .OVERFLOW_FLAG_ONE(ovf1), .TIMER2_OVERFLOW_FLAG(ovf2),
    .TIMER2_EXTERNAL_FLAG(ext2));
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      $display("MISMATCH %0t timeout", $time);
      final_report();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input addr_t a, input logic w, input byte_t d, output byte_t q,
                     output logic e);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input addr_t a, input byte_t d);
    byte_t q;
    logic e;
    apb(a, 1'b1, d, q, e);
  endtask
  task automatic rd(input addr_t a, input byte_t x);
    byte_t q;
    logic e;
    apb(a, 1'b0, 8'h00, q, e);
    chk(q, x);
  endtask
  task automatic ack(input bit one);
    @(posedge clock);
    if (one) ack1 <= 1'b1; else ack0 <= 1'b1;
    @(posedge clock);
    ack0 <= 1'b0;
    ack1 <= 1'b0;
    @(posedge clock);
  endtask
  task automatic t_reset();
    byte_t q;
    logic e;
    rd(8'h08, 8'h00);
    rd(8'h00, 8'h00);
    apb(8'h40, 1'b0, 8'h00, q, e);
    chk({7'h00, e}, 8'h01);
    $display("reset test done");
  endtask
  task automatic t_mode1();
    wr(8'h14, 8'hFF);
    wr(8'h18, 8'hFF);
    wr(8'h00, 8'h01);
    wr(8'h04, 8'h10);
    for (int i = 0; i < 80 && ovf0 !== 1'b1; i++) @(posedge clock);
    chk({7'h00, ovf0}, 8'h01);
    wr(8'h04, 8'h20);
    rd(8'h14, 8'h00);
    rd(8'h18, 8'h00);
    ack(1'b0);
    chk({7'h00, ovf0}, 8'h00);
    $display("mode 1 test done");
  endtask
  task automatic t_timer_one();
    wr(8'h00, 8'h40);
    wr(8'h1C, 8'hFF);
    wr(8'h20, 8'h05);
    wr(8'h04, 8'h40);
    pm.fall(1);
    rd(8'h1C, 8'hE0);
    rd(8'h20, 8'h06);
    chk({7'h00, ovf1}, 8'h00);
    wr(8'h1C, 8'h1F);
    wr(8'h20, 8'hFF);
    pm.fall(1);
    rd(8'h20, 8'h00);
    chk({7'h00, ovf1}, 8'h01);
    ack(1'b1);
    wr(8'h00, 8'h60);
    wr(8'h1C, 8'hFF);
    wr(8'h20, 8'hA5);
    pm.fall(1);
    rd(8'h1C, 8'hA5);
    rd(8'h20, 8'hA5);
    chk({7'h00, ovf1}, 8'h01);
    wr(8'h00, 8'h70);
    pm.fall(1);
    rd(8'h1C, 8'hA5);
    $display("timer one test done");
  endtask
  task automatic t_gate();
    wr(8'h00, 8'h0D);
    wr(8'h14, 8'h00);
    wr(8'h18, 8'h00);
    wr(8'h04, 8'h10);
    pm.set_pin(2, 1'b0);
    pm.fall(0);
    rd(8'h14, 8'h00);
    pm.set_pin(2, 1'b1);
    pm.fall(0);
    rd(8'h14, 8'h01);
    $display("gate test done");
  endtask
  task automatic t_timer2();
    wr(8'h0C, 8'h0F);
    wr(8'h24, 8'h34);
    wr(8'h28, 8'h12);
    pm.fall(5);
    rd(8'h2C, 8'h34);
    rd(8'h30, 8'h12);
    chk({7'h00, ext2}, 8'h01);
    wr(8'h10, 8'h08);
    wr(8'h24, 8'h77);
    pm.fall(5);
    rd(8'h2C, 8'h77);
    rd(8'h24, 8'h00);
    pm.fall(4);
    rd(8'h24, 8'h01);
    wr(8'h24, 8'hFF);
    wr(8'h28, 8'hFF);
    pm.fall(4);
    rd(8'h28, 8'h00);
    repeat (40) @(posedge clock);
    chk({6'h00, ovf2, ext2}, 8'h03);
    wr(8'h10, 8'h00);
    wr(8'h0C, 8'h0E);
    @(posedge clock);
    chk({6'h00, ovf2, ext2}, 8'h00);
    wr(8'h24, 8'hFF);
    wr(8'h28, 8'hFF);
    pm.fall(4);
    rd(8'h24, 8'h77);
    rd(8'h28, 8'h12);
    chk({7'h00, ovf2}, 8'h01);
    wr(8'h24, 8'h00);
    pm.fall(5);
    rd(8'h24, 8'h77);
    chk({7'h00, ext2}, 8'h01);
    $display("timer2 test done");
  endtask
  initial clock = 1'b0;
  initial begin
    reset_n <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h00000000;
    ack0 <= 1'b0;
    ack1 <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    t_reset();
    t_mode1();
    t_timer_one();
    t_gate();
    t_timer2();
    final_report();
  end
endmodule
`default_nettype wire
